/* File: design/pwmtb_core.sv */
// Purpose: PWM time base counter, period, special event trigger and pin ownership
// Assumes: One clock clk_sys at 40 MHz, asynchronous active-low reset
// Notes: AHB-Lite slave with zero wait states and OKAY responses only
//
// Functional notes
// - Count register bit 15 reads one when counting down, zero counting up.
// - Count register bits 14-0 hold the live count; software reads and writes.
// - Period register bits 14-0 hold a writable 15-bit period value.
// - Period register bit 15 reads zero and ignores writes.
// - Trigger fires on down-count when select is one, up-count when zero.
// - Trigger direction select is compared against the count direction flag.
// - Trigger compare value is compared against count bits 14-0.
// - Bits 11-8 per pair: one independent mode, zero complementary.
// - Bits 7-4 give each high pin to PWM when one, else GPIO.
// - Bits 3-0 give each low pin to PWM when one, else GPIO.
// - Bits 15-12 of pair mode and pin enable register read zero.
// - Pin enable reset state comes from a nonvolatile configuration strap.
//
// The address map and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/100ps
module pwmtb_core
  import pwmtb_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Nonvolatile pin ownership strap
  input wire logic cfg_pin_pwm_owned,
  // Pin ownership and pair mode
  output logic [PAIRS-1:0] pair_independent_select,
  output logic [PAIRS-1:0] high_pin_output_enable,
  output logic [PAIRS-1:0] low_pin_output_enable,
  // Events
  output logic special_event_trigger,
  output logic irq
);

  // Register state
  logic [CNT_W-1:0] timebase_count;
  pwmtb_dir_t count_down_flag;
  logic [CNT_W-1:0] timebase_period;
  logic [CNT_W-1:0] trigger_compare_value;
  logic trigger_direction_select;
  pwmtb_pins_t pins;
  logic run;
  logic [EV_W-1:0] ev_status;
  logic [EV_W-1:0] ev_mask;
  pwmtb_req_t req;

  // Strap synchroniser and load sequencing
  logic strap_meta;
  logic strap_sync;
  logic [1:0] strap_cnt;
  logic strap_loaded;

  // Bus decode
  logic addr_phase;
  logic wr_now;
  logic rd_status_now;
  logic trig_cond;
  logic trig_cond_q;
  logic trig_rise;
  logic period_hit;
  logic [EV_W-1:0] ev_set;

  // Reads a register by offset; unmapped offsets read as zero
  function automatic logic [31:0] read_mux(input logic [7:0] a);
    logic [31:0] v;
    v = WORD_ZERO;
    if (a == OFF_COUNT) begin
      v[DIR_BIT] = count_down_flag;
      v[CNT_W-1:0] = timebase_count;
    end else if (a == OFF_PERIOD) begin
      v[CNT_W-1:0] = timebase_period;
    end else if (a == OFF_COMPARE) begin
      v[DIR_BIT] = trigger_direction_select;
      v[CNT_W-1:0] = trigger_compare_value;
    end else if (a == OFF_PAIR_PIN) begin
      v[PMOD_LSB +: PAIRS] = pins.independent;
      v[PENH_LSB +: PAIRS] = pins.high_en;
      v[PENL_LSB +: PAIRS] = pins.low_en;
    end else if (a == OFF_CONTROL) begin
      v[CTRL_RUN_BIT] = run;
    end else if (a == OFF_STATUS) begin
      v[EV_W-1:0] = ev_status;
    end else if (a == OFF_MASK) begin
      v[EV_W-1:0] = ev_mask;
    end
    return v;
  endfunction : read_mux

  // Address phase accepted on hready; only the low byte of haddr decodes
  // hsize is not decoded: only whole-word access is expected
  assign addr_phase = hsel && (htrans == HTRANS_NONSEQ) && hready;
  assign wr_now = req.valid && req.write;
  assign rd_status_now = addr_phase && !hwrite && (haddr[7:0] == OFF_STATUS);

  // Address phase capture
  // A low hready keeps the request of a stalled bus in place
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      req <= '0;
    end else if (hready) begin
      req.valid <= addr_phase;
      req.write <= hwrite;
      req.addr <= haddr[7:0];
    end
  end

  // Read data is prepared at the address edge so the data phase needs no wait
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      hrdata <= WORD_ZERO;
    end else if (addr_phase && !hwrite) begin
      hrdata <= read_mux(haddr[7:0]);
    end
  end

  // Ready from the first clock after reset, always OKAY; registered so outputs come from flops
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // Time base: continuous up/down between zero and the period.
  // A software write to the count wins over the counting step that cycle.
  // A zero period parks the count at zero while the flag keeps toggling.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      timebase_count <= CNT_RST;
      count_down_flag <= PWMTB_UP;
    end else if (wr_now && req.addr == OFF_COUNT) begin
      timebase_count <= hwdata[CNT_W-1:0];
    end else if (run) begin
      if (count_down_flag == PWMTB_UP) begin
        if (timebase_count >= timebase_period) begin
          count_down_flag <= PWMTB_DOWN;
          if (timebase_count != CNT_RST) begin
            timebase_count <= timebase_count - 15'h0001;
          end
        end else begin
          timebase_count <= timebase_count + 15'h0001;
        end
      end else begin
        if (timebase_count == CNT_RST) begin
          count_down_flag <= PWMTB_UP;
          if (timebase_period != CNT_RST) begin
            timebase_count <= 15'h0001;
          end
        end else begin
          timebase_count <= timebase_count - 15'h0001;
        end
      end
    end
  end

  // Period, compare and control registers
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      timebase_period <= CNT_RST;
      trigger_compare_value <= CNT_RST;
      trigger_direction_select <= 1'b0;
      run <= 1'b0;
      ev_mask <= EV_RST;
    end else if (wr_now) begin
      if (req.addr == OFF_PERIOD) begin
        timebase_period <= hwdata[CNT_W-1:0];
      end else if (req.addr == OFF_COMPARE) begin
        trigger_direction_select <= hwdata[DIR_BIT];
        trigger_compare_value <= hwdata[CNT_W-1:0];
      end else if (req.addr == OFF_CONTROL) begin
        run <= hwdata[CTRL_RUN_BIT];
      end else if (req.addr == OFF_MASK) begin
        ev_mask <= hwdata[EV_W-1:0];
      end
    end
  end

  // Strap passes two flops before use
  // The strap stands in for the nonvolatile configuration word
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      strap_meta <= 1'b0;
      strap_sync <= 1'b0;
    end else begin
      strap_meta <= cfg_pin_pwm_owned;
      strap_sync <= strap_meta;
    end
  end

  // Count out the synchroniser latency before trusting the strap
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      strap_cnt <= 2'h0;
      strap_loaded <= 1'b0;
    end else if (!strap_loaded) begin
      if (strap_cnt == STRAP_SETTLE) begin
        strap_loaded <= 1'b1;
      end else begin
        strap_cnt <= strap_cnt + 2'h1;
      end
    end
  end

  // Pair mode and pin enables; enables take the strap once after reset.
  // A software write to the enables before the strap lands is overridden by the strap.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pins.independent <= PAIR_RST;
      pins.high_en <= PAIR_RST;
      pins.low_en <= PAIR_RST;
    end else if (!strap_loaded && strap_cnt == STRAP_SETTLE) begin
      pins.high_en <= {PAIRS{strap_sync}};
      pins.low_en <= {PAIRS{strap_sync}};
    end else if (wr_now && req.addr == OFF_PAIR_PIN) begin
      pins.independent <= hwdata[PMOD_LSB +: PAIRS];
      pins.high_en <= hwdata[PENH_LSB +: PAIRS];
      pins.low_en <= hwdata[PENL_LSB +: PAIRS];
    end
  end

  // Pin ownership outputs, three flops per pair
  // A cleared enable hands the pin back to general purpose I/O
  genvar g;
  generate
    for (g = 0; g < PAIRS; g++) begin : g_pair
      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          pair_independent_select[g] <= 1'b0;
          high_pin_output_enable[g] <= 1'b0;
          low_pin_output_enable[g] <= 1'b0;
        end else begin
          pair_independent_select[g] <= pins.independent[g];
          high_pin_output_enable[g] <= pins.high_en[g];
          low_pin_output_enable[g] <= pins.low_en[g];
        end
      end
    end
  endgenerate

  // Trigger needs direction and count match together
  assign trig_cond = (trigger_direction_select == count_down_flag)
                     && (trigger_compare_value == timebase_count);
  assign period_hit = run && (count_down_flag == PWMTB_UP)
                      && (timebase_count == timebase_period);

  // Rising edge of the condition gives a single-cycle pulse.
  // All compared fields clear to zero and the flag to up, so the condition
  // already holds out of reset; the history flop starts high to match, or
  // every reset would fire a false trigger into the converter.
  assign trig_rise = trig_cond && !trig_cond_q;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      trig_cond_q <= 1'b1;
      special_event_trigger <= 1'b0;
    end else begin
      trig_cond_q <= trig_cond;
      special_event_trigger <= trig_rise;
    end
  end

  // Event sources for the sticky status
  assign ev_set[EV_TRIG_BIT] = trig_rise;
  assign ev_set[EV_PERIOD_BIT] = period_hit;

  // Sticky status cleared by a read; a new event in the same cycle survives
  // The read returns the value from before the clear, so no event is lost
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ev_status <= EV_RST;
    end else if (rd_status_now) begin
      ev_status <= ev_set;
    end else begin
      ev_status <= ev_status | ev_set;
    end
  end

  // Level interrupt while any unmasked status bit is set
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(ev_status & ev_mask);
    end
  end

endmodule : pwmtb_core

/* File: design/pwmtb_pkg.sv */
// Purpose: Shared constants and types for the PWM time base and event block
// Assumes: 32-bit AHB-Lite data, each register on one aligned word
// Notes: Registers hold up to 16 bits in the low half; upper bits read as zero
package pwmtb_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_COUNT = 8'h00;
  localparam logic [7:0] OFF_PERIOD = 8'h04;
  localparam logic [7:0] OFF_COMPARE = 8'h08;
  localparam logic [7:0] OFF_PAIR_PIN = 8'h0c;
  localparam logic [7:0] OFF_CONTROL = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  localparam logic [7:0] OFF_MASK = 8'h18;

  // Field positions
  localparam int CNT_W = 15;
  localparam int DIR_BIT = 15;
  localparam int PAIRS = 4;
  localparam int PMOD_LSB = 8;
  localparam int PENH_LSB = 4;
  localparam int PENL_LSB = 0;
  localparam int CTRL_RUN_BIT = 0;
  localparam int EV_TRIG_BIT = 0;
  localparam int EV_PERIOD_BIT = 1;
  localparam int EV_W = 2;

  // Reset values
  localparam logic [CNT_W-1:0] CNT_RST = 15'h0000;
  localparam logic [PAIRS-1:0] PAIR_RST = 4'h0;
  localparam logic [EV_W-1:0] EV_RST = 2'h0;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

  // Strap settle time: two synchroniser stages, then load
  localparam logic [1:0] STRAP_SETTLE = 2'h2;

  // AHB transfer type and size codes
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  // Time base direction
  typedef enum logic {
    PWMTB_UP = 1'b0,
    PWMTB_DOWN = 1'b1
  } pwmtb_dir_t;

  // Captured address phase
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
  } pwmtb_req_t;

  // Per-pair pin ownership and mode
  typedef struct packed {
    logic [PAIRS-1:0] independent;
    logic [PAIRS-1:0] high_en;
    logic [PAIRS-1:0] low_en;
  } pwmtb_pins_t;

endpackage : pwmtb_pkg

/* File: verification/pwmtb_chk.sv */
// Purpose: Port-level checks of bus answers, pin fields and the event pulse
// Assumes: Strap input changes only while reset is low; no pin write before strap load
// Notes: Tracks data phases itself, as register contents are not visible
`timescale 1ns/100ps
module pwmtb_chk
  import pwmtb_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // Pins and events
  input wire logic cfg_pin_pwm_owned,
  input wire logic [PAIRS-1:0] pair_independent_select,
  input wire logic [PAIRS-1:0] high_pin_output_enable,
  input wire logic [PAIRS-1:0] low_pin_output_enable,
  input wire logic special_event_trigger
);
  logic take;
  logic wr_pin;
  pwmtb_req_t ph;
  logic [2:0] boot;
  // Transfer accepted now, and pin write sitting in its data phase
  assign take = hsel && htrans == HTRANS_NONSEQ && hready;
  assign wr_pin = ph.valid && ph.write && ph.addr == OFF_PAIR_PIN;
  // Data phase record; boot saturates so it never wraps into a false match
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ph <= '0;
      boot <= 3'h0;
    end else begin
      ph <= {take, hwrite, haddr[7:0]};
      if (boot != 3'h7) begin
        boot <= boot + 3'h1;
      end
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  property p_ready;
    $past(rst_n) |-> hreadyout && !hresp;
  endproperty
  property p_hold;
    !(take && !hwrite) |=> $stable(hrdata);
  endproperty
  property p_pin_rd;
    ph.valid && !ph.write && ph.addr == OFF_PAIR_PIN |-> hrdata[31:12] == 20'h0;
  endproperty
  property p_per_rd;
    ph.valid && !ph.write && ph.addr == OFF_PERIOD |-> hrdata[31:15] == 17'h0;
  endproperty
  property p_pulse;
    special_event_trigger |=> !special_event_trigger;
  endproperty
  property p_mode;
    $changed(pair_independent_select) |-> $past(wr_pin) || $past(wr_pin, 2);
  endproperty
  property p_strap;
    boot == 3'h5 |-> high_pin_output_enable == {PAIRS{cfg_pin_pwm_owned}}
      && low_pin_output_enable == {PAIRS{cfg_pin_pwm_owned}};
  endproperty
  property p_clear;
    boot == 3'h1 |-> pair_independent_select == 4'h0 && high_pin_output_enable == 4'h0;
  endproperty
  property p_boot_quiet;
    boot == 3'h1 |-> !special_event_trigger;
  endproperty
  a_ready: assert property (p_ready) else $error("bus not ready or not OKAY");
  a_hold: assert property (p_hold) else $error("read data moved without a read");
  a_pin_rd: assert property (p_pin_rd) else $error("pin register top bits set");
  a_per_rd: assert property (p_per_rd) else $error("period top bit set");
  a_pulse: assert property (p_pulse) else $error("trigger longer than one cycle");
  a_mode: assert property (p_mode) else $error("pair mode moved without write");
  a_strap: assert property (p_strap) else $error("pin enables differ from strap");
  a_clear: assert property (p_clear) else $error("fields not clear after reset");
  a_boot_quiet: assert property (p_boot_quiet) else $error("trigger out of reset");
  cover property (special_event_trigger);
  cover property (wr_pin);
  cover property (boot == 3'h5);
endmodule : pwmtb_chk

/* File: verification/pwmtb_gate_model.sv */
// Purpose: Gate driver side, counting pins handed to the PWM
// Assumes: Pins not owned fall back to general I/O
// Notes: Waveforms are not modelled; only ownership is seen
`timescale 1ns/100ps
module pwmtb_gate_model
  import pwmtb_pkg::*;
(
  // Ownership from the block
  input wire logic [PAIRS-1:0] high_pin_output_enable,
  input wire logic [PAIRS-1:0] low_pin_output_enable,
  // Gates now driven by the PWM
  output logic [3:0] owned_cnt
);
  // Each enabled pin is one gate under PWM control
  always_comb begin
    owned_cnt = 4'h0;
    for (int i = 0; i < PAIRS; i++) begin
      owned_cnt += 4'(high_pin_output_enable[i]) + 4'(low_pin_output_enable[i]);
    end
  end
endmodule : pwmtb_gate_model

/* File: verification/pwmtb_tb_top.sv */
// Purpose: Register, pin and trigger tests over the bus
// Assumes: Strap high at the first reset, low at a second reset in mid-run
// Notes: Count is held still where trigger timing must be exact
`timescale 1ns/100ps
module pwmtb_tb_top
  import pwmtb_pkg::*;
;
  logic clk_sys = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, cfg_pin_pwm_owned = 1'b1;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = HSIZE_WORD;
  logic hready, hreadyout, hresp, special_event_trigger, irq, down;
  logic [PAIRS-1:0] pair_independent_select, high_pin_output_enable, low_pin_output_enable;
  logic [3:0] owned_cnt;
  logic [7:0] offs [5] = '{OFF_COUNT, OFF_PERIOD, OFF_COMPARE, OFF_MASK, 8'h1c};
  int failures = 0, checks = 0, pulses = 0, p0 = 0;
  assign hready = hreadyout;
  pwmtb_core pwmtb_core_inst (.*);
  pwmtb_gate_model pwmtb_gate_model_inst (.*);
  // Clock at 40 MHz
  always #12.5 clk_sys = ~clk_sys;
  // Event pulses seen
  always @(posedge clk_sys) if (special_event_trigger === 1'b1) pulses <= pulses + 1;
  // One single transfer; read data left in r
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_sys); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : xfer
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string nm);
    xfer(1'b0, a, 32'h0);
    chk(nm, r, exp);
  endtask : rd
  task automatic end_sim;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : end_sim
  // Watchdog, far beyond the roughly 130 cycles the tests need
  initial begin
    repeat (5000) @(posedge clk_sys);
    failures++;
    end_sim();
  end
  // Main sequence
  initial begin
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (5) @(posedge clk_sys);
    rd(OFF_PAIR_PIN, 32'h0000_00ff, "pins reset");
    chk("gates", {28'h0, owned_cnt}, 32'h8);
    xfer(1'b1, 8'h1c, 32'hffff_ffff);
    foreach (offs[i]) rd(offs[i], 32'h0, "zero");
    xfer(1'b1, OFF_PAIR_PIN, 32'hffff_ffff);
    rd(OFF_PAIR_PIN, 32'h0000_0fff, "pins ro");
    xfer(1'b1, OFF_PAIR_PIN, 32'h0000_0a5c);
    rd(OFF_PAIR_PIN, 32'h0000_0a5c, "pins rw");
    chk("pins", {20'h0, pair_independent_select, high_pin_output_enable,
      low_pin_output_enable}, 32'h0000_0a5c);
    chk("gates", {28'h0, owned_cnt}, 32'h4);
    xfer(1'b1, OFF_PERIOD, 32'hffff_ffff);
    rd(OFF_PERIOD, 32'h0000_7fff, "period");
    xfer(1'b1, OFF_COUNT, 32'h0000_ffff);
    rd(OFF_COUNT, 32'h0000_7fff, "count");
    // Static count: trigger on up match, none on wrong direction
    xfer(1'b1, OFF_MASK, 32'h1);
    xfer(1'b1, OFF_COUNT, 32'h3);
    xfer(1'b0, OFF_STATUS, 32'h0);
    p0 = pulses;
    xfer(1'b1, OFF_COMPARE, 32'h3);
    repeat (6) @(posedge clk_sys);
    chk("pulse", pulses - p0, 32'h1);
    chk("irq", {31'h0, irq}, 32'h1);
    rd(OFF_STATUS, 32'h1, "status");
    @(posedge clk_sys);
    chk("irq clr", {31'h0, irq}, 32'h0);
    xfer(1'b1, OFF_COMPARE, 32'h8003);
    repeat (6) @(posedge clk_sys);
    chk("no pulse", pulses - p0, 32'h1);
    // Masked event still sets status
    xfer(1'b1, OFF_MASK, 32'h0);
    xfer(1'b1, OFF_COMPARE, 32'h3);
    repeat (4) @(posedge clk_sys);
    chk("masked", {31'h0, irq}, 32'h0);
    rd(OFF_STATUS, 32'h1, "status m");
    // Running counter must turn down; stride 3 sweeps every phase
    xfer(1'b1, OFF_PERIOD, 32'h4);
    xfer(1'b1, OFF_CONTROL, 32'h1);
    down = 1'b0;
    repeat (8) begin
      xfer(1'b0, OFF_COUNT, 32'h0);
      down |= r[DIR_BIT];
      chk("range", {31'h0, r[14:0] <= 15'h4}, 32'h1);
      @(posedge clk_sys);
    end
    chk("down", {31'h0, down}, 32'h1);
    // Stopped count: direction and value together fire once
    xfer(1'b1, OFF_CONTROL, 32'h0);
    xfer(1'b0, OFF_COUNT, 32'h0);
    p0 = pulses;
    xfer(1'b1, OFF_COMPARE, {16'h0, r[15:0]});
    repeat (6) @(posedge clk_sys);
    chk("dir pulse", pulses - p0, 32'h1);
    // Run left both events behind: trigger on up-count and period match
    rd(OFF_STATUS, 32'h3, "status run");
    // Second reset with the strap low: pins go to GPIO, fields clear
    cfg_pin_pwm_owned <= 1'b0;
    rst_n <= 1'b0;
    repeat (4) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (5) @(posedge clk_sys);
    rd(OFF_PAIR_PIN, 32'h0, "pins strap low");
    chk("gates low", {28'h0, owned_cnt}, 32'h0);
    rd(OFF_COUNT, 32'h0, "count clear");
    rd(OFF_COMPARE, 32'h0, "compare clear");
    end_sim();
  end
endmodule : pwmtb_tb_top
bind pwmtb_core pwmtb_chk pwmtb_chk_inst (.*);
